// ==== include/dsc_pkg.sv ====
// Summary of operation
// - Either input open requests motor current off
// - Motor power removed within 20 ms
// - Dropouts totalling 0.5 ms or less ignored
// - Utility interrupted by cutoff needs cancel, restart
// - Servo ready held off during cutoff
// - Ready when both closed and drive blocked
// - Cutoff drops holding brake, skipping delay
// - Dynamic brake applied when stop method selects
// - Cutoff alone never raises fault alarm
// - Monitor active only when both inputs open
// - One input open ten seconds raises fault
// - Disable command then closed inputs leave cutoff
// - Monitor follows inputs within 20 ms
package dsc_pkg;
   // ==================================================
   // Timing
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned GLITCH_TIME_US = 500;
   localparam int unsigned CUTOFF_TIME_MS = 20;
   localparam int unsigned MONITOR_TIME_MS = 20;
   localparam int unsigned MISMATCH_TIME_MS = 10000;
   localparam int unsigned GLITCH_CYC = (GLITCH_TIME_US * CLK_KHZ) / 1000;
   localparam int unsigned CUTOFF_CYC = CUTOFF_TIME_MS * CLK_KHZ;
   localparam int unsigned MONITOR_CYC = MONITOR_TIME_MS * CLK_KHZ;
   localparam int unsigned MISMATCH_CYC = MISMATCH_TIME_MS * CLK_KHZ;
   // ==================================================
   // Register map (byte addresses)
   localparam int ADR_W = 4;
   localparam logic [ADR_W-1:0] OFF_CTRL = 4'h0;
   localparam logic [ADR_W-1:0] OFF_CMD = 4'h4;
   localparam logic [ADR_W-1:0] OFF_STATUS = 4'h8;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'hffff_ff01;
   localparam int CTRL_DYN_BRAKE = 0;
   localparam int CTRL_DELAY_LSB = 8;
   localparam int DELAY_W = 24;
   localparam int CMD_ENABLE = 0;
   localparam int CMD_DISABLE = 1;
   localparam int CMD_UTIL_START = 2;
   localparam int CMD_UTIL_CANCEL = 3;
   localparam int CMD_CLEAR = 4;
   localparam int ST_A_OPEN = 0;
   localparam int ST_B_OPEN = 1;
   localparam int ST_READY = 2;
   localparam int ST_POWER = 3;
   localparam int ST_FAULT = 4;
   localparam int ST_UTIL_RUN = 5;
   localparam int ST_UTIL_LOCK = 6;
   localparam int ST_ESTOP = 7;
   localparam int ST_DISABLE_SEEN = 8;
   localparam int ST_REFUSED = 9;
   localparam int ST_STATE_LSB = 12;
   // ==================================================
   // Drive states
   typedef enum logic [3:0] {
      DSC_BLOCKED = 4'h1,
      DSC_RUN = 4'h2,
      DSC_STOPPING = 4'h4,
      DSC_CUTOFF = 4'h8
   } dsc_state_t;
endpackage : dsc_pkg

// ==== src/dsc_chan_filter.sv ====
`timescale 1ns/100ps
`default_nettype none
module dsc_chan_filter #(
   parameter int unsigned GLITCH_CYC = dsc_pkg::GLITCH_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic pin_n_i,
   output logic open_o
);
   import dsc_pkg::*;
   localparam int CW = $clog2(GLITCH_CYC + 2);
   localparam logic [CW-1:0] LIMIT = CW'(GLITCH_CYC + 1);
   localparam logic [CW-1:0] ONE = CW'(1);
   localparam logic [CW-1:0] ZERO = CW'(0);

   logic sync0_reg;
   logic sync1_reg;
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   logic open_next;
   wire raw_open = ~sync1_reg;
   wire at_limit = (cnt_reg == LIMIT);
   wire at_zero = (cnt_reg == ZERO);

   // ==================================================
   // Integrating filter
   // Counts up while open and down while closed, so repeated short
   // dropouts add up; only a total beyond the threshold is believed.
   // glitch threshold
   assign cnt_next = (raw_open && !at_limit) ? cnt_reg + ONE :
                     (!raw_open && !at_zero) ? cnt_reg - ONE : cnt_reg;
   assign open_next = at_limit ? 1'b1 : (at_zero ? 1'b0 : open_o);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync0_reg <= 1'b1;
         sync1_reg <= 1'b1;
         cnt_reg <= ZERO;
         open_o <= 1'b0;
      end else if (ce_i) begin
         sync0_reg <= pin_n_i;
         sync1_reg <= sync0_reg;
         cnt_reg <= cnt_next;
         open_o <= open_next;
      end
   end

   a_glitch_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && !open_o && cnt_reg < LIMIT) |=> !open_o)
      else $error("open recognised before glitch threshold");
endmodule : dsc_chan_filter
`default_nettype wire

// ==== src/dsc_safety_cutoff.sv ====
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module dsc_safety_cutoff #(
   parameter int unsigned GLITCH_CYC = dsc_pkg::GLITCH_CYC,
   parameter int unsigned MISMATCH_CYC = dsc_pkg::MISMATCH_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [dsc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic safety_stop_in_a_n_i,
   input wire logic safety_stop_in_b_n_i,
   output logic motor_power_o,
   output logic servo_ready_o,
   output logic holding_brake_out_o,
   output logic dynamic_brake_o,
   output logic fault_alarm_out_o,
   output logic external_monitor_out_o
);
   import dsc_pkg::*;
   localparam int MW = $clog2(MISMATCH_CYC + 1);
   localparam logic [MW-1:0] MIS_LAST = MW'(MISMATCH_CYC - 1);
   localparam logic [MW-1:0] MIS_ONE = MW'(1);
   localparam logic [MW-1:0] MIS_ZERO = MW'(0);
   localparam logic [DELAY_W-1:0] DLY_ONE = DELAY_W'(1);
   localparam logic [DELAY_W-1:0] DLY_ZERO = DELAY_W'(0);

   // ==================================================
   // Input channels
   logic a_open;
   logic b_open;

   dsc_chan_filter #(.GLITCH_CYC(GLITCH_CYC)) u_filt_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_n_i(safety_stop_in_a_n_i),
      .open_o(a_open)
   );

   dsc_chan_filter #(.GLITCH_CYC(GLITCH_CYC)) u_filt_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_n_i(safety_stop_in_b_n_i),
      .open_o(b_open)
   );

   wire cutoff_req = a_open | b_open;
   wire both_closed = ~a_open & ~b_open;
   wire both_open = a_open & b_open;
   wire one_open = a_open ^ b_open;

   // ==================================================
   // Register bus
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] status;
   logic [31:0] rd_data;
   wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire sel_ctrl = (wb_adr_i == OFF_CTRL);
   wire sel_cmd = (wb_adr_i == OFF_CMD);
   wire sel_status = (wb_adr_i == OFF_STATUS);
   wire wr_ctrl = bus_req & wb_we_i & sel_ctrl;
   wire wr_cmd = bus_req & wb_we_i & sel_cmd & wb_sel_i[0];
   wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                        {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign ctrl_next = ((ctrl_reg & ~wmask) | (wb_dat_i & wmask)) & CTRL_MASK;

   wire cmd_enable = wr_cmd & wb_dat_i[CMD_ENABLE];
   wire cmd_disable = wr_cmd & wb_dat_i[CMD_DISABLE];
   wire cmd_util_start = wr_cmd & wb_dat_i[CMD_UTIL_START];
   wire cmd_util_cancel = wr_cmd & wb_dat_i[CMD_UTIL_CANCEL];
   wire cmd_clear = wr_cmd & wb_dat_i[CMD_CLEAR];

   wire stop_method_select = ctrl_reg[CTRL_DYN_BRAKE];
   wire [DELAY_W-1:0] brake_release_delay_param = ctrl_reg[CTRL_DELAY_LSB +: DELAY_W];

   // Unmapped addresses and the write-only command word read as zero
   always_comb begin
      if (sel_ctrl) begin
         rd_data = ctrl_reg;
      end else if (sel_status) begin
         rd_data = status;
      end else begin
         rd_data = 32'h0000_0000;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         ctrl_reg <= CTRL_RESET;
      end else if (ce_i) begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
         if (wr_ctrl) begin
            ctrl_reg <= ctrl_next;
         end
      end
   end

   // ==================================================
   // Drive state machine
   dsc_state_t state_reg;
   dsc_state_t state_next;
   logic [DELAY_W-1:0] dly_reg;
   logic [DELAY_W-1:0] dly_next;
   logic disable_seen_reg;
   logic util_run_reg;
   logic util_lock_reg;
   logic fault_reg;
   logic refused_reg;
   logic [MW-1:0] mis_reg;

   wire in_blocked = (state_reg == DSC_BLOCKED);
   wire in_cutoff = (state_reg == DSC_CUTOFF);
   // A utility that was running when the inputs opened stays frozen
   // utility lock
   wire util_motion = util_run_reg & ~util_lock_reg & in_blocked & both_closed;
   wire enable_ok = in_blocked & both_closed & ~fault_reg & ~util_lock_reg;
   wire enable_bad = cmd_enable & ~enable_ok & ~(state_reg == DSC_RUN);

   always_comb begin
      state_next = state_reg;
      dly_next = dly_reg;
      case (state_reg)
         DSC_BLOCKED: begin
            if (cmd_enable && enable_ok) begin
               state_next = DSC_RUN;
            end
         end
         DSC_RUN: begin
            if (cmd_disable) begin
               state_next = DSC_STOPPING;
               dly_next = brake_release_delay_param;
            end
         end
         DSC_STOPPING: begin
            if (dly_reg == DLY_ZERO) begin
               state_next = DSC_BLOCKED;
            end else begin
               dly_next = dly_reg - DLY_ONE;
            end
         end
         DSC_CUTOFF: begin
            if (disable_seen_reg && both_closed) begin
               state_next = DSC_BLOCKED;
            end
         end
         default: begin
            state_next = DSC_CUTOFF;
         end
      endcase
      if (cutoff_req) begin
         state_next = DSC_CUTOFF;
         dly_next = DLY_ZERO;
      end
   end

   wire mis_done = one_open & (mis_reg == MIS_LAST);
   wire [MW-1:0] mis_next = !one_open ? MIS_ZERO :
                            (mis_reg == MIS_LAST) ? mis_reg : mis_reg + MIS_ONE;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= DSC_BLOCKED;
         dly_reg <= DLY_ZERO;
         mis_reg <= MIS_ZERO;
      end else if (ce_i) begin
         state_reg <= state_next;
         dly_reg <= dly_next;
         mis_reg <= mis_next;
      end
   end

   // Set terms win over clears in util_lock_reg, fault_reg, refused_reg; clears win in util_run_reg, disable_seen_reg
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         disable_seen_reg <= 1'b0;
         util_run_reg <= 1'b0;
         util_lock_reg <= 1'b0;
         fault_reg <= 1'b0;
         refused_reg <= 1'b0;
      end else if (ce_i) begin
         disable_seen_reg <= in_cutoff & (disable_seen_reg | cmd_disable);
         util_run_reg <= (util_run_reg | cmd_util_start) & ~cmd_util_cancel;
         util_lock_reg <= (cutoff_req & util_run_reg) |
                          (util_lock_reg & ~cmd_util_cancel);
         fault_reg <= mis_done | (fault_reg & ~cmd_clear);
         refused_reg <= enable_bad | (refused_reg & ~cmd_clear);
      end
   end

   // ==================================================
   // Outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         motor_power_o <= 1'b0;
         servo_ready_o <= 1'b0;
         holding_brake_out_o <= 1'b0;
         dynamic_brake_o <= 1'b0;
         fault_alarm_out_o <= 1'b0;
         external_monitor_out_o <= 1'b0;
      end else if (ce_i) begin
         motor_power_o <= ~cutoff_req & ((state_next == DSC_RUN) |
                          (state_next == DSC_STOPPING) | util_motion);
         servo_ready_o <= ~cutoff_req & (state_next == DSC_BLOCKED) & both_closed;
         holding_brake_out_o <= ~cutoff_req & (state_next == DSC_RUN);
         dynamic_brake_o <= (state_next == DSC_CUTOFF) & stop_method_select;
         fault_alarm_out_o <= mis_done | (fault_reg & ~cmd_clear);
         external_monitor_out_o <= both_open;
      end
   end

   assign status = {16'h0000, state_reg, 2'b00, refused_reg, disable_seen_reg,
                    in_cutoff, util_lock_reg, util_run_reg, fault_reg,
                    motor_power_o, servo_ready_o, b_open, a_open};

   // ==================================================
   // Checks
   a_power_cut: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cutoff_req) |=> (!motor_power_o && state_reg == DSC_CUTOFF))
      else $error("motor power not removed after cutoff request");

   a_ready_cutoff: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cutoff_req) |=> !servo_ready_o)
      else $error("servo ready shown during cutoff");

   a_ready_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && in_blocked && both_closed && !cmd_enable && !cutoff_req) |=> servo_ready_o)
      else $error("servo ready missing in blocked state");

   a_brake_drop: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cutoff_req && holding_brake_out_o) |=> !holding_brake_out_o && dly_reg == 0)
      else $error("holding brake not dropped at cutoff");

   a_dyn_brake: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && cutoff_req) |=> (dynamic_brake_o == $past(stop_method_select)))
      else $error("dynamic brake does not follow stop method");

   a_no_alarm: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && both_open && !fault_alarm_out_o) |=> !fault_alarm_out_o)
      else $error("alarm raised by cutoff alone");

   a_monitor_both: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i |=> (external_monitor_out_o == $past(a_open && b_open)))
      else $error("monitor output disagrees with inputs");

   a_mismatch_fault: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && one_open && mis_reg == MIS_LAST) |=> fault_alarm_out_o)
      else $error("mismatch alarm not raised");

   a_exit_needs_off: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && in_cutoff && !disable_seen_reg) |=> !in_blocked)
      else $error("cutoff left without disable command");

   a_util_frozen: assert property (@(posedge clk_i) disable iff (rst_i)
      (ce_i && util_lock_reg && !cmd_util_cancel) |=>
      (!motor_power_o && state_reg != DSC_RUN))
      else $error("locked utility resumed motion");
endmodule : dsc_safety_cutoff
`default_nettype wire

// ==== verification/dsc_safety_unit.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Safety unit model on the far side of the cutoff
module dsc_safety_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic guard_open_i,
   input wire logic stuck_b_i,
   input wire logic monitor_i,
   output logic pin_a_n_o,
   output logic pin_b_n_o,
   output logic reset_ok_o
);
   logic guard_reg;
   logic seen_reg;
   // both channels driven
   // Channel b stays closed only when a contact fault is commanded
   assign pin_a_n_o = ~guard_open_i;
   assign pin_b_n_o = ~guard_open_i | stuck_b_i;
   always_ff @(posedge clk_i) begin
      guard_reg <= guard_open_i;
      if (rst_i || (guard_open_i && !guard_reg)) begin
         seen_reg <= 1'b0;
      end else if (guard_open_i && monitor_i) begin
         seen_reg <= 1'b1;
      end
   end
   assign reset_ok_o = seen_reg;
endmodule : dsc_safety_unit
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dsc_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, guard, stuck, pa, pb, rok;
   logic pwr, rdy, brk, dyn, flt, mon;
   logic [3:0] sel, lanes;
   logic [ADR_W-1:0] adr;
   logic [31:0] dat, dout, r;
   int num_errors, checks_done;
   dsc_safety_cutoff #(.GLITCH_CYC(8), .MISMATCH_CYC(50)) i_dsc_safety_cutoff (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dout), .wb_ack_o(ack), .safety_stop_in_a_n_i(pa),
      .safety_stop_in_b_n_i(pb), .motor_power_o(pwr), .servo_ready_o(rdy),
      .holding_brake_out_o(brk), .dynamic_brake_o(dyn),
      .fault_alarm_out_o(flt), .external_monitor_out_o(mon));
   dsc_safety_unit i_dsc_safety_unit (.clk_i(clk_i), .rst_i(rst_i),
      .guard_open_i(guard), .stuck_b_i(stuck), .monitor_i(mon),
      .pin_a_n_o(pa), .pin_b_n_o(pb), .reset_ok_o(rok));
   // ==========================================
   // Checking and bus tasks
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic complete_run;
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // Entered just after an edge; waits for ack, never for a fixed count
   task automatic wbc(input logic w, input logic [ADR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= lanes;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check("wb_ack", n < 20, 1);
      q = dout;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask : wbc
   task automatic wr(input logic [ADR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      wbc(1'b1, a, d, q);
   endtask : wr
   task automatic wait_pwr(input logic lvl);
      int n;
      n = 0;
      while (pwr !== lvl && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      check("pwr_time", n < 40, 1);
   endtask : wait_pwr
   // ==========================================
   // Scenarios
   task automatic t_reset;
      tick(2);
      check("ready", rdy, 1);
      check("mon_idle", mon, 0);
      wbc(1'b0, OFF_CTRL, 0, r);
      check("ctrl_rst", r, CTRL_RESET);
      wbc(1'b0, 4'hc, 0, r);
      check("unmapped", r, 0);
      wbc(1'b0, OFF_STATUS, 0, r);
      check("state", r[15:12], 4'h1);
      wr(OFF_CTRL, 32'hffff_ffff);
      wbc(1'b0, OFF_CTRL, 0, r);
      check("ctrl_mask", r, CTRL_MASK);
      // Only byte lane 0 written, upper lanes keep their ones
      lanes = 4'h1;
      wr(OFF_CTRL, 32'h0);
      lanes = 4'hf;
      wbc(1'b0, OFF_CTRL, 0, r);
      check("ctrl_lane", r, 32'hffff_ff00);
      // Command without lane 0 must not enable the drive
      lanes = 4'he;
      wr(OFF_CMD, 32'h1);
      lanes = 4'hf;
      check("cmd_lane", rdy, 1);
   endtask : t_reset
   task automatic t_cutoff;
      int n;
      wr(OFF_CTRL, 32'h0000_1001);
      wr(OFF_CMD, 32'h1);
      tick(3);
      check("run_pwr", pwr, 1);
      check("run_rdy", rdy, 0);
      guard <= 1'b1;
      tick(8);
      guard <= 1'b0;
      n = 0;
      repeat (24) begin
         @(posedge clk_i);
         n += (pwr !== 1'b1);
      end
      check("glitch", n, 0);
      guard <= 1'b1;
      n = 0;
      while (pwr === 1'b1 && n < 40) begin
         check("brake_on", brk, 1);
         @(posedge clk_i);
         n++;
      end
      check("cut_time", n < 40, 1);
      check("brake_off", brk, 0);
      check("dyn", dyn, 1);
      check("rdy_cut", rdy, 0);
      check("alarm", flt, 0);
      check("mon_on", mon, 1);
      tick(2);
      check("feedback", rok, 1);
      wr(OFF_CMD, 32'h1);
      wbc(1'b0, OFF_STATUS, 0, r);
      check("refused", r[ST_REFUSED], 1);
      guard <= 1'b0;
      tick(20);
      check("stay_cut", rdy, 0);
      check("mon_off", mon, 0);
      wr(OFF_CMD, 32'h12);
      tick(3);
      check("rdy_back", rdy, 1);
   endtask : t_cutoff
   task automatic t_mismatch;
      int n;
      wr(OFF_CMD, 32'h1);
      tick(3);
      stuck <= 1'b1;
      guard <= 1'b1;
      wait_pwr(1'b0);
      check("mon_one", mon, 0);
      check("alarm_early", flt, 0);
      n = 0;
      while (flt !== 1'b1 && n < 80) begin
         @(posedge clk_i);
         n++;
      end
      check("alarm_time", n > 40 && n < 60, 1);
      check("no_feedback", rok, 0);
      guard <= 1'b0;
      stuck <= 1'b0;
      tick(20);
      wr(OFF_CMD, 32'h12);
      tick(3);
      check("alarm_clr", flt, 0);
   endtask : t_mismatch
   task automatic t_util;
      wr(OFF_CMD, 32'h4);
      tick(3);
      check("util_pwr", pwr, 1);
      guard <= 1'b1;
      wait_pwr(1'b0);
      guard <= 1'b0;
      tick(20);
      wr(OFF_CMD, 32'h2);
      tick(3);
      check("util_hold", pwr, 0);
      wbc(1'b0, OFF_STATUS, 0, r);
      check("util_lock", r[ST_UTIL_LOCK], 1);
      wr(OFF_CMD, 32'h8);
      wr(OFF_CMD, 32'h4);
      tick(3);
      check("util_again", pwr, 1);
      wr(OFF_CMD, 32'h8);
   endtask : t_util
   // Normal stop keeps power for the delay; the cutoff path must not
   task automatic t_stop;
      wr(OFF_CMD, 32'h1);
      tick(3);
      check("stop_brk_on", brk, 1);
      wr(OFF_CMD, 32'h2);
      check("stop_brk", brk, 0);
      tick(10);
      check("stop_delay", pwr, 1);
      tick(8);
      check("stop_pwr", pwr, 0);
      check("stop_rdy", rdy, 1);
   endtask : t_stop
   // ==========================================
   // Clock, watchdog and main sequence
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      #100000;
      num_errors++;
      complete_run();
   end
   initial begin
      num_errors = 0;
      checks_done = 0;
      rst_i = 1'b1;
      {cyc, stb, we, guard, stuck} = 5'h0;
      sel = 4'h0;
      lanes = 4'hf;
      adr = '0;
      dat = 32'h0;
      tick(20);
      rst_i <= 1'b0;
      t_reset();
      t_cutoff();
      t_mismatch();
      t_util();
      t_stop();
      complete_run();
   end
endmodule : testbench
`default_nettype wire
